/* File: src/spi_cfg_defs.svh */
// register offsets, field positions, reset values and counts of the serial port configuration block
`ifndef SPI_CFG_DEFS_SVH
`define SPI_CFG_DEFS_SVH

// byte offsets on the register bus
`define OFF_CTRL_ONE 32'h0000_0000
`define OFF_CTRL_TWO 32'h0000_0004
`define OFF_RUN 32'h0000_0008
`define OFF_STATUS 32'h0000_000C

// first control register fields
`define C1_EDGE_BIT 8
`define C1_POL_BIT 6
`define C1_MASTER_BIT 5
`define C1_SEC_MSB 4
`define C1_SEC_LSB 2
`define C1_PRI_MSB 1
`define C1_PRI_LSB 0
`define C1_WRITE_MASK 16'h017F
`define CTRL_ONE_RESET 16'h0000

// second control register fields
`define C2_FRM_EN_BIT 15
`define C2_FS_DIR_BIT 14
`define C2_FS_POL_BIT 13
`define C2_FS_EDGE_BIT 1
`define C2_EBUF_BIT 0
`define C2_WRITE_MASK 16'hE003
`define CTRL_TWO_RESET 16'h0000

// run register and status register fields
`define RUN_START_BIT 0
`define ST_BUSY_BIT 0
`define ST_FRAME_BIT 1
`define ST_FRAMED_BIT 2
`define ST_MASTER_BIT 3
`define ST_CNT_MSB 15
`define ST_CNT_LSB 8

// burst length and divider limits
`define BURST_BITS 4'h8
`define SEC_BASE 10'h008
`define MIN_RATIO 10'h002

`endif

/* File: src/spi_cfg_pkg.sv */
// types shared by the serial port configuration block
`include "spi_cfg_defs.svh"
package spi_cfg_pkg;

    // burst sequencer states
    typedef enum logic [1:0] {LINK_IDLE, LINK_LEAD, LINK_BITS} link_state_t;

    // all state of the configuration block
    typedef struct packed {
        logic [15:0] ctrlOne;
        logic [15:0] ctrlTwo;
        link_state_t link;
        logic [3:0] bitCnt;
        logic runDiv;
        logic frameSeen;
        logic [7:0] edgeCnt;
        logic [2:0] sckSync;
        logic [2:0] ssSync;
        logic ack;
        logic [31:0] rdata;
        logic sckOut;
        logic sckOe;
        logic ssOut;
        logic ssOe;
    } cfg_state_t;

    // all state of the clock divider
    typedef struct packed {
        logic [9:0] cnt;
        logic phase;
        logic periodEnd;
    } div_state_t;

endpackage : spi_cfg_pkg

/* File: src/spi_sck_divider.sv */
// serial clock divider built from the primary and secondary prescale codes
`timescale 1ns/1ps
`include "spi_cfg_defs.svh"
module spi_sck_divider (
    input wire logic mclk,
    input wire logic rst,
    input wire logic run,
    input wire logic [1:0] priSel,
    input wire logic [2:0] secSel,
    output logic phaseActive,
    output logic periodEnd
);
    spi_cfg_pkg::div_state_t s_q; // registered divider state
    spi_cfg_pkg::div_state_t s_d; // next divider state
    logic [9:0] priRatio; // primary ratio 1, 4, 16 or 64
    logic [9:0] ratio; // full division ratio
    logic [9:0] half; // cycles spent in the active phase

    // ratio from the codes: 11 is 1:1 down to 00 at 64:1, 111 is 1:1 down to 000 at 8:1
    always_comb
    begin
        priRatio = 10'h001 << {(2'h3 - priSel), 1'b0};
        ratio = 10'((priRatio * (`SEC_BASE - {7'h00, secSel})) & 10'h3FF);
        // 1:1 overall cannot toggle a pin, clamp to 2:1
        if (ratio < `MIN_RATIO)
        begin
            ratio = `MIN_RATIO;
        end
        half = ratio >> 1;
    end

    // counter parks at the period end so a new run starts with a full period
    always_comb
    begin
        s_d = s_q;
        if (rst)
        begin
            s_d = '0;
        end
        else if (run)
        begin
            // wrap at the end of each serial clock period
            s_d.cnt = (s_q.cnt >= ratio - 10'h001) ? 10'h000 : s_q.cnt + 10'h001;
            s_d.phase = (s_d.cnt < half);
            s_d.periodEnd = (s_d.cnt == ratio - 10'h001);
        end
        else
        begin
            // stopped: no phase, no period events
            s_d.cnt = ratio - 10'h001;
            s_d.phase = 1'b0;
            s_d.periodEnd = 1'b0;
        end
    end

    // state register
    always_ff @(posedge mclk)
    begin
        s_q <= s_d;
    end

    assign phaseActive = s_q.phase;
    assign periodEnd = s_q.periodEnd;
endmodule : spi_sck_divider

/* File: src/spi_clock_and_frame_config.sv */
// serial port clock and frame configuration with a classic wishbone register slave
//
// The address map and the Wishbone interface to the registers were decided locally.
`timescale 1ns/1ps
`include "spi_cfg_defs.svh"
// Operation
// - polarity bit sets serial clock idle level
// - secondary code 111 is 1:1, 000 is 8:1
// - primary code 11 is 1:1, 00 is 64:1
// - prescalers act only in master mode
// - clock edge bit ignored while framed
// - second register bit layout, reset zero
// - unused second register bits read zero
// - framed enable turns framed operation on
// - sync direction: input when 1, output when 0
// - sync polarity high when 1, framed only
// - clock equals input clock over prescaler product, clamped to at least 2:1
module spi_clock_and_frame_config (
    input wire logic mclk,
    input wire logic rst,
    // classic wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // serial clock pin
    input wire logic sckIn,
    output logic sckOut,
    output logic sckOe,
    // slave select pin, used for frame sync
    input wire logic ssIn,
    output logic ssOut,
    output logic ssOe,
    // configuration seen by the data path
    output logic dataEdgeSelect,
    output logic framedMode,
    output logic bufferEnhanced,
    output logic masterMode
);
    spi_cfg_pkg::cfg_state_t s_q; // registered block state
    spi_cfg_pkg::cfg_state_t s_d; // next block state
    logic divPhase; // divider in active half of period
    logic divEnd; // divider at last cycle of period
    // register map: control one, control two, run strobe, status word
    // status: busy, frame seen, framed, master, slave clock edge count

    // divider runs only while a master burst is in flight
    // it parks while idle so the first period of a burst is full length
    spi_sck_divider spi_sck_divider_inst (
        .mclk(mclk),
        .rst(rst),
        .run(s_q.runDiv),
        .priSel(s_q.ctrlOne[`C1_PRI_MSB:`C1_PRI_LSB]),
        .secSel(s_q.ctrlOne[`C1_SEC_MSB:`C1_SEC_LSB]),
        .phaseActive(divPhase),
        .periodEnd(divEnd)
    );

    // merge write data into a 16-bit register through byte lanes and a mask
    // lanes above bit 15 carry nothing, sel_i[3:2] are ignored
    function automatic logic [15:0] lane_write(
        input logic [15:0] old,
        input logic [31:0] data,
        input logic [3:0] sel,
        input logic [15:0] mask
    );
        logic [15:0] laneMask;
        laneMask = {{8{sel[1]}}, {8{sel[0]}}} & mask;
        lane_write = (old & ~laneMask) | (data[15:0] & laneMask);
    endfunction : lane_write

    // combinational next state
    always_comb
    begin
        logic reqValid; // new request not yet answered
        logic wrTake; // write committed on this edge
        logic masterOn; // port is serial clock master
        logic idleLevel; // serial clock idle level
        logic framedOn; // framed operation enabled
        logic frameMaster; // frame sync driven by this port
        logic frameSlave; // frame sync received on the pin
        logic syncLevel; // active level of frame sync
        logic syncCoincide; // sync during first bit
        logic startReq; // software asks for a burst
        logic ssActive; // frame sync pulse asserted
        logic [15:0] status; // status word for reads
        logic [31:0] word; // aligned word address
        reqValid = 1'b0;
        wrTake = 1'b0;
        masterOn = 1'b0;
        idleLevel = 1'b0;
        framedOn = 1'b0;
        frameMaster = 1'b0;
        frameSlave = 1'b0;
        syncLevel = 1'b0;
        syncCoincide = 1'b0;
        startReq = 1'b0;
        ssActive = 1'b0;
        status = 16'h0000;
        word = {adr_i[31:2], 2'b00};

        // default: every field holds unless a branch below moves it
        s_d = s_q;

        // decoded configuration
        // frame master and frame slave exclude each other by construction
        masterOn = s_q.ctrlOne[`C1_MASTER_BIT];
        idleLevel = s_q.ctrlOne[`C1_POL_BIT];
        framedOn = s_q.ctrlTwo[`C2_FRM_EN_BIT];
        frameSlave = framedOn & s_q.ctrlTwo[`C2_FS_DIR_BIT];
        frameMaster = framedOn & ~s_q.ctrlTwo[`C2_FS_DIR_BIT];
        syncLevel = s_q.ctrlTwo[`C2_FS_POL_BIT];
        syncCoincide = s_q.ctrlTwo[`C2_FS_EDGE_BIT];

        // two-stage synchronisers, third stage only for edges
        s_d.sckSync = {s_q.sckSync[1:0], sckIn};
        s_d.ssSync = {s_q.ssSync[1:0], ssIn};

        // bus handshake: ack one cycle after the request, dropped next cycle
        // a request still up while ack stands is not taken again, so a
        // master that drops stb on the edge it sees ack gets only one ack
        // unmapped addresses are answered too, so a master never hangs
        reqValid = cyc_i & stb_i & ~s_q.ack;
        wrTake = cyc_i & stb_i & we_i & s_q.ack;
        s_d.ack = reqValid;

        // status word assembly
        // rebuilt every cycle from live state, nothing cached
        status[`ST_BUSY_BIT] = (s_q.link != spi_cfg_pkg::LINK_IDLE);
        status[`ST_FRAME_BIT] = s_q.frameSeen;
        status[`ST_FRAMED_BIT] = framedOn;
        status[`ST_MASTER_BIT] = masterOn;
        status[`ST_CNT_MSB:`ST_CNT_LSB] = s_q.edgeCnt;

        // read data latched with the request, held through the ack
        // reads have no side effects, so any address may be polled
        if (reqValid & ~we_i)
        begin
            case (word)
                `OFF_CTRL_ONE: s_d.rdata = {16'h0000, s_q.ctrlOne};
                // unused bits stay zero in storage and read as zero
                `OFF_CTRL_TWO: s_d.rdata = {16'h0000, s_q.ctrlTwo & `C2_WRITE_MASK};
                `OFF_RUN: s_d.rdata = 32'h0000_0000;
                `OFF_STATUS: s_d.rdata = {16'h0000, status};
                // unmapped: answered with zero
                default: s_d.rdata = 32'h0000_0000;
            endcase
        end

        // register writes take effect on the acknowledged edge
        if (wrTake)
        begin
            case (word)
                // first control register, writable fields only
                `OFF_CTRL_ONE: s_d.ctrlOne = lane_write(s_q.ctrlOne, dat_i, sel_i, `C1_WRITE_MASK);
                // second control register, bits 12 to 2 ignored
                `OFF_CTRL_TWO: s_d.ctrlTwo = lane_write(s_q.ctrlTwo, dat_i, sel_i, `C2_WRITE_MASK);
                // run register is a write-only strobe, nothing is stored
                // burst start handled below
                `OFF_RUN: startReq = sel_i[0] & dat_i[`RUN_START_BIT];
                // write one clears the frame flag
                `OFF_STATUS:
                begin
                    if (sel_i[0] & dat_i[`ST_FRAME_BIT])
                    begin
                        s_d.frameSeen = 1'b0;
                    end
                end
                // unmapped: write dropped
                default: s_d.frameSeen = s_d.frameSeen;
            endcase
        end

        // frame sync received: leading edge to the active level, framed only
        // only the synchronised copy is read, never the raw pin
        // a flag from an earlier frame stays until software clears it
        if (frameSlave & (s_q.ssSync[1] == syncLevel) & (s_q.ssSync[2] != syncLevel))
        begin
            // a new frame beats a clear in the same cycle
            s_d.frameSeen = 1'b1;
        end

        // slave clock edges counted from the idle to the active level
        // eight-bit count wraps silently, software works with differences
        // counting stops while the port is master
        if (~masterOn & (s_q.sckSync[2] == idleLevel) & (s_q.sckSync[1] != idleLevel))
        begin
            s_d.edgeCnt = s_q.edgeCnt + 8'h01;
        end

        // burst sequencer
        case (s_q.link)
            spi_cfg_pkg::LINK_IDLE:
            begin
                s_d.bitCnt = 4'h0;
                // only a master makes clocks
                // a start from a slave or while busy is dropped without trace
                if (startReq & masterOn)
                begin
                    s_d.runDiv = 1'b1;
                    // preceding sync needs a lead period
                    if (frameMaster & ~syncCoincide)
                    begin
                        s_d.link = spi_cfg_pkg::LINK_LEAD;
                    end
                    else
                    begin
                        s_d.link = spi_cfg_pkg::LINK_BITS;
                    end
                end
            end
            spi_cfg_pkg::LINK_LEAD:
            begin
                // one full clock period of sync before the first bit
                if (divEnd)
                begin
                    s_d.link = spi_cfg_pkg::LINK_BITS;
                end
            end
            spi_cfg_pkg::LINK_BITS:
            begin
                // one bit per divider period
                // config changes act at once, there is no shadow copy
                if (divEnd)
                begin
                    s_d.bitCnt = s_q.bitCnt + 4'h1;
                    if (s_q.bitCnt == `BURST_BITS - 4'h1)
                    begin
                        s_d.link = spi_cfg_pkg::LINK_IDLE;
                        s_d.runDiv = 1'b0;
                    end
                end
            end
            default:
            begin
                s_d.link = spi_cfg_pkg::LINK_IDLE;
                s_d.runDiv = 1'b0;
            end
        endcase

        // leaving master mode stops a burst at once
        // overrides the sequencer so no stray period is left behind
        // sckOe drops the cycle after, through the pin logic below
        if (~masterOn)
        begin
            s_d.link = spi_cfg_pkg::LINK_IDLE;
            s_d.runDiv = 1'b0;
        end

        // serial clock pin: idle level outside bits, inverted in active phase
        // registered, so the pin cannot glitch when the ratio changes
        s_d.sckOe = masterOn;
        if ((s_q.link == spi_cfg_pkg::LINK_BITS) & divPhase)
        begin
            s_d.sckOut = ~idleLevel;
        end
        else
        begin
            s_d.sckOut = idleLevel;
        end

        // frame sync pulse: lead period, or first bit when coinciding
        // the inactive level stands whenever the port owns the pin
        ssActive = frameMaster & ((s_q.link == spi_cfg_pkg::LINK_LEAD) |
            ((s_q.link == spi_cfg_pkg::LINK_BITS) & (s_q.bitCnt == 4'h0) & syncCoincide));
        s_d.ssOe = frameMaster;
        s_d.ssOut = ssActive ? syncLevel : ~syncLevel;

        // synchronous reset to documented values
        // placed last so reset wins over any bus access in the same cycle
        if (rst)
        begin
            s_d = '0;
            s_d.ctrlOne = `CTRL_ONE_RESET;
            s_d.ctrlTwo = `CTRL_TWO_RESET;
            s_d.link = spi_cfg_pkg::LINK_IDLE;
        end
    end

    // state register
    // one register bank, reset folded into the next-state logic
    always_ff @(posedge mclk)
    begin
        s_q <= s_d;
    end

    // bus outputs
    // dat_o keeps the last read word, meaningful only with ack_o
    assign dat_o = s_q.rdata;
    assign ack_o = s_q.ack;

    // pin outputs, all registered
    assign sckOut = s_q.sckOut;
    assign sckOe = s_q.sckOe;
    assign ssOut = s_q.ssOut;
    assign ssOe = s_q.ssOe;

    // edge select forced to zero in framed modes
    // configuration levels come straight from the stored bits
    assign dataEdgeSelect = s_q.ctrlOne[`C1_EDGE_BIT] & ~s_q.ctrlTwo[`C2_FRM_EN_BIT];
    assign framedMode = s_q.ctrlTwo[`C2_FRM_EN_BIT];
    assign bufferEnhanced = s_q.ctrlTwo[`C2_EBUF_BIT];
    assign masterMode = s_q.ctrlOne[`C1_MASTER_BIT];
endmodule : spi_clock_and_frame_config

/* File: sim/spi_cfg_monitor.sv */
// assertion checker on the configuration block ports
`timescale 1ns/1ps
`include "spi_cfg_defs.svh"
module spi_cfg_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [31:0] adr_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic sckOe,
    input wire logic ssOe,
    input wire logic dataEdgeSelect,
    input wire logic framedMode,
    input wire logic bufferEnhanced,
    input wire logic masterMode
);
    // one clock domain, reset masks all checks
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // request answered in the next cycle
    property p_ack_answer; cyc_i && stb_i && !ack_o |=> ack_o; endproperty
    a_ack_answer: assert property (p_ack_answer) else $error("request not acknowledged");
    // acknowledge is a single pulse
    property p_ack_pulse; ack_o |=> !ack_o; endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
    // ack, pin enables and mode outputs cleared out of reset
    property p_rst_zero;
        $fell(rst) |-> !ack_o && !sckOe && !ssOe && !masterMode && !framedMode && !bufferEnhanced;
    endproperty
    a_rst_zero: assert property (p_rst_zero) else $error("outputs not zero after reset");
    // slave role never drives the clock pin
    property p_slave_quiet; !masterMode |=> !sckOe; endproperty
    a_slave_quiet: assert property (p_slave_quiet) else $error("clock driven in slave role");
    // clock drive starts only as master
    property p_sck_master; $rose(sckOe) |-> masterMode; endproperty
    a_sck_master: assert property (p_sck_master) else $error("clock drive without master");
    // edge select masked in framed mode
    property p_edge_framed; framedMode |-> !dataEdgeSelect; endproperty
    a_edge_framed: assert property (p_edge_framed) else $error("edge select used while framed");
    // sync pin drive starts only when framed
    property p_sync_framed; $rose(ssOe) |-> framedMode; endproperty
    a_sync_framed: assert property (p_sync_framed) else $error("sync driven while not framed");
    // unused second register bits read zero
    property p_two_unused;
        ack_o && !$past(we_i) && $past(adr_i) == `OFF_CTRL_TWO |-> dat_o[12:2] == 11'h000 && dat_o[31:16] == 16'h0000;
    endproperty
    a_two_unused: assert property (p_two_unused) else $error("unused bits read nonzero");
    // main scenarios reached
    c_master_drive: cover property (sckOe && masterMode);
    c_sync_drive: cover property (ssOe);
    c_framed_on: cover property ($rose(framedMode));
endmodule : spi_cfg_monitor

/* File: sim/spi_far_device.sv */
// far-side serial device model driving the clock and select pins
`timescale 1ns/1ps
module spi_far_device (
    input wire logic mclk,
    output logic sckIn,
    output logic ssIn
);
    // clock stands still, select released to its pull-up
    initial
    begin
        sckIn = 1'b0;
        ssIn = 1'b1;
    end
    // n clock pulses around idle level idl, slow half periods
    task automatic burst(input int n, input logic idl);
        sckIn <= idl;
        for (int i = 0; i < n; i++)
        begin
            repeat (4) @(posedge mclk);
            sckIn <= ~idl;
            repeat (4) @(posedge mclk);
            sckIn <= idl;
        end
    endtask : burst
    // one frame sync pulse at active level act
    task automatic syncPulse(input logic act);
        ssIn <= ~act;
        repeat (4) @(posedge mclk);
        ssIn <= act;
        repeat (4) @(posedge mclk);
        ssIn <= ~act;
    endtask : syncPulse
endmodule : spi_far_device

/* File: sim/spi_clock_and_frame_config_test.sv */
// self-checking bench for the serial port configuration block
`timescale 1ns/1ps
`include "spi_cfg_defs.svh"
module spi_clock_and_frame_config_test;
    logic mclk = 1'b0;
    logic rst, cyc_i, stb_i, we_i, ack_o, sckIn, sckOut, sckOe, ssIn, ssOut, ssOe;
    logic dataEdgeSelect, framedMode, bufferEnhanced, masterMode, pol;
    logic [31:0] adr_i, dat_i, dat_o, q;
    logic [3:0] sel_i;
    int n_errors = 0;
    int cmp_count = 0;
    int n, m, r;
    spi_clock_and_frame_config spi_clock_and_frame_config_inst (.mclk(mclk), .rst(rst), .cyc_i(cyc_i),
        .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i), .dat_o(dat_o), .ack_o(ack_o),
        .sckIn(sckIn), .sckOut(sckOut), .sckOe(sckOe), .ssIn(ssIn), .ssOut(ssOut), .ssOe(ssOe),
        .dataEdgeSelect(dataEdgeSelect), .framedMode(framedMode), .bufferEnhanced(bufferEnhanced),
        .masterMode(masterMode));
    spi_far_device spi_far_device_inst (.mclk(mclk), .sckIn(sckIn), .ssIn(ssIn));
    // 100 MHz clock
    always #5 mclk = ~mclk;
    // verdict and end of run
    task automatic tally_and_finish;
        if (n_errors == 0 && cmp_count > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask : tally_and_finish
    // word compare
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp)
        begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    // single pin compare
    task automatic chkBit(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask : chkBit
    // one classic wishbone cycle, held until ack
    task automatic wb(input logic w, input logic [31:0] a, input logic [31:0] d, output logic [31:0] rd_q);
        int t;
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i <= w;
        adr_i <= a;
        dat_i <= d;
        t = 0;
        do
        begin
            @(posedge mclk);
            t++;
        end while (ack_o !== 1'b1 && t < 50);
        rd_q = dat_o;
        if (t >= 50)
            n_errors++;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        we_i <= 1'b0;
        @(posedge mclk);
    endtask : wb
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] x;
        wb(1'b1, a, d, x);
    endtask : wr
    task automatic rd(input logic [31:0] a, output logic [31:0] d);
        wb(1'b0, a, 32'h0, d);
    endtask : rd
    // cycles until a pin reaches lvl, bounded
    task automatic waitFor(input logic onSs, input logic lvl, output int c);
        c = 0;
        do
        begin
            @(posedge mclk);
            c++;
        end while ((onSs ? ssOut : sckOut) !== lvl && c < 3000);
        if (c >= 3000)
            n_errors++;
    endtask : waitFor
    // poll busy until the burst is over
    task automatic waitDone;
        logic [31:0] s;
        int t;
        t = 0;
        do
        begin
            rd(`OFF_STATUS, s);
            t++;
        end while (s[0] !== 1'b0 && t < 3000);
        if (t >= 3000)
            n_errors++;
    endtask : waitDone
    // watchdog well above the expected run
    initial
    begin
        #900000;
        n_errors++;
        tally_and_finish;
    end
    // main sequence
    initial
    begin
        rst = 1'b1;
        {cyc_i, stb_i, we_i} = 3'h0;
        adr_i = 32'h0;
        dat_i = 32'h0;
        sel_i = 4'h3;
        repeat (12) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(`OFF_CTRL_ONE, q);
        chk(q, 32'h0);
        rd(`OFF_CTRL_TWO, q);
        chk(q, 32'h0);
        wr(`OFF_CTRL_TWO, 32'hFFFF_FFFF);
        rd(`OFF_CTRL_TWO, q);
        chk(q, 32'h0000_E003);
        chk({30'h0, framedMode, bufferEnhanced}, 32'h3);
        wr(`OFF_CTRL_ONE, 32'h100);
        chkBit(dataEdgeSelect, 1'b0);
        wr(`OFF_CTRL_TWO, 32'h0);
        chkBit(dataEdgeSelect, 1'b1);
        wr(32'h10, 32'hFFFF);
        rd(32'h10, q);
        chk(q, 32'h0);
        wr(`OFF_CTRL_ONE, 32'h40);
        wr(`OFF_RUN, 32'h1);
        chkBit(sckOe, 1'b0);
        spi_far_device_inst.burst(5, 1'b1);
        repeat (6) @(posedge mclk);
        rd(`OFF_STATUS, q);
        chk(q & 32'hFF09, 32'h0500);
        for (int p = 0; p < 4; p++)
        begin
            for (int s = 0; s < 8; s++)
            begin
                pol = s[0];
                r = (1 << (2 * (3 - p))) * (8 - s);
                if (r < 2)
                    r = 2;
                wr(`OFF_CTRL_ONE, 32'(s[0] * 64 + 32 + s * 4 + p));
                // registered pin shows the new idle level one edge later
                @(posedge mclk);
                chkBit(sckOut, pol);
                wr(`OFF_RUN, 32'h1);
                waitFor(1'b0, ~pol, n);
                waitFor(1'b0, pol, n);
                waitFor(1'b0, ~pol, m);
                chk(32'(n + m), 32'(r));
                chkBit(sckOe, 1'b1);
                waitDone;
            end
        end
        wr(`OFF_CTRL_ONE, 32'h20);
        chkBit(masterMode, 1'b1);
        wr(`OFF_RUN, 32'h1);
        repeat (20) @(posedge mclk);
        rd(`OFF_STATUS, q);
        chk(q & 32'h9, 32'h9);
        wr(`OFF_CTRL_ONE, 32'h0);
        @(posedge mclk);
        chkBit(sckOe, 1'b0);
        chkBit(masterMode, 1'b0);
        rd(`OFF_STATUS, q);
        chk(q & 32'hF, 32'h0);
        // bit 0 of f picks sync polarity, bit 1 the coinciding sync edge
        for (int f = 0; f < 4; f++)
        begin
            wr(`OFF_CTRL_TWO, 32'h8000 | 32'((f & 1) << 13) | 32'(f & 2));
            wr(`OFF_CTRL_ONE, 32'h3F);
            chkBit(ssOe, 1'b1);
            chkBit(ssOut, ~f[0]);
            wr(`OFF_RUN, 32'h1);
            waitFor(1'b1, f[0], n);
            chkBit(n < 20, 1'b1);
            waitFor(1'b1, ~f[0], m);
            chkBit(m < 20, 1'b1);
            waitDone;
        end
        wr(`OFF_CTRL_TWO, 32'hE000);
        wr(`OFF_CTRL_ONE, 32'h0);
        chkBit(ssOe, 1'b0);
        spi_far_device_inst.syncPulse(1'b1);
        repeat (6) @(posedge mclk);
        rd(`OFF_STATUS, q);
        chk(q & 32'h6, 32'h6);
        wr(`OFF_STATUS, 32'h2);
        rd(`OFF_STATUS, q);
        chk(q & 32'h6, 32'h4);
        // second reset in mid-run brings the second register back to zero
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        rd(`OFF_CTRL_TWO, q);
        chk(q, 32'h0);
        tally_and_finish;
    end
endmodule : spi_clock_and_frame_config_test
// checker attached to the block's ports
bind spi_clock_and_frame_config spi_cfg_monitor spi_cfg_monitor_inst (.mclk(mclk), .rst(rst), .cyc_i(cyc_i),
    .stb_i(stb_i), .we_i(we_i), .adr_i(adr_i), .dat_o(dat_o), .ack_o(ack_o), .sckOe(sckOe), .ssOe(ssOe),
    .dataEdgeSelect(dataEdgeSelect), .framedMode(framedMode), .bufferEnhanced(bufferEnhanced),
    .masterMode(masterMode));
